// [rtl/usb_host_capability_params.sv]
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "usb_cap_params.svh"
// How it works
// RQ1 - bit 4 reports port power switches
// RQ2 - port power bit follows switch capability
// RQ3 - bits 3 to 0 report port count
// RQ4 - only that many port registers addressable
// RQ5 - port count is never zero
// RQ6 - structural parameters at offset 04h
// RQ7 - capability parameters word at offset 08h
// RQ8 - both registers read-only, writes ignored
module usb_host_capability_params #(
    parameter int PORT_COUNT = 2,
    parameter bit POWER_SWITCH = 1'b1
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire usb_cap_pkg::addr_t avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire usb_cap_pkg::word_t avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output usb_cap_pkg::word_t avs_readdata,
    output logic avs_waitrequest,
    output logic [14:0] port_power
);
    import usb_cap_pkg::*;

    // elaboration-time refusal of port count zero and of port counts the 4-bit field cannot carry
    generate
        if (PORT_COUNT < 1 || PORT_COUNT > 15) begin : g_bad_count
            $error("port count must be 1 to 15"); // RQ5
        end
    endgenerate

    localparam logic [3:0] PORT_CNT = 4'(PORT_COUNT);

    usb_port_if #(.N(15)) pif ();

    bus_state_e state_r;
    word_t rdata_r;
    logic [14:0] power_out_r;
    word_t rdata_nxt;
    word_t struct_word;
    logic port_hit;
    logic [3:0] port_idx;
    logic [7:0] port_ofs;

    always_comb begin
        struct_word = 32'h0000_0000;
        struct_word[`FLD_PORT_COUNT_MSB:`FLD_PORT_COUNT_LSB] = PORT_CNT; // RQ3
        struct_word[`BIT_PORT_POWER_SWITCH] = POWER_SWITCH; // RQ1
    end

    assign port_ofs = avs_address - `OFS_PORT_BASE;
    assign port_idx = port_ofs[5:2];
    assign port_hit = (avs_address >= `OFS_PORT_BASE) && (port_ofs[1:0] == 2'b00)
        && (port_ofs < 8'(PORT_COUNT * 4)); // RQ4

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (avs_address == `OFS_STRUCTURAL_PARAMS) begin
            rdata_nxt = struct_word; // RQ6
        end else if (avs_address == `OFS_CAPABILITY_PARAMS) begin
            rdata_nxt = `RST_CAPABILITY; // RQ7
        end else if (port_hit) begin
            rdata_nxt[`BIT_PORTREG_POWER] = pif.power_on[port_idx]; // RQ4
        end
    end

    genvar g;
    generate
        for (g = 0; g < 15; g++) begin : g_wr
            assign pif.power_wr[g] = (state_r == bus_idle) && avs_write && port_hit
                && (port_idx == 4'(g)) && avs_byteenable[1]; // RQ4
            assign pif.power_val[g] = avs_writedata[`BIT_PORTREG_POWER];
        end
    endgenerate
    assign pif.switch_present = POWER_SWITCH; // RQ2

    usb_port_power #(.N(15)) u_power (
        .clk_sys(clk_sys),
        .reset(reset),
        .pif(pif)
    );

    // one wait cycle then answer; writes to capability words fall through
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_r <= bus_idle;
        end else begin
            case (state_r)
                bus_idle: begin
                    if (avs_read || avs_write) begin
                        state_r <= bus_answer;
                    end
                end
                bus_answer: state_r <= bus_idle;
                default: state_r <= bus_idle;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata_r <= 32'h0000_0000;
        end else if (state_r == bus_idle && avs_read) begin
            rdata_r <= rdata_nxt; // RQ8
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(state_r == bus_idle && (avs_read || avs_write));
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            power_out_r <= 15'h0000;
        end else begin
            power_out_r <= pif.power_on & ~(15'h7fff << PORT_COUNT); // RQ4
        end
    end

    assign avs_readdata = rdata_r;
    assign port_power = power_out_r;
endmodule // usb_host_capability_params

// [rtl/usb_cap_params.svh]
`ifndef USB_CAP_PARAMS_SVH
`define USB_CAP_PARAMS_SVH

`define OFS_STRUCTURAL_PARAMS 8'h04
`define OFS_CAPABILITY_PARAMS 8'h08
`define OFS_PORT_BASE 8'h40
`define PORT_REG_STRIDE 8'h04
`define BIT_PORT_POWER_SWITCH 4
`define FLD_PORT_COUNT_LSB 0
`define FLD_PORT_COUNT_MSB 3
`define BIT_PORTREG_POWER 12
`define BIT_PORTREG_CONNECT 0
`define RST_PORT_COUNT 4'h2
`define RST_POWER_SWITCH 1'b1
`define RST_CAPABILITY 32'h0000_0000
`define READ_LATENCY 1

`endif

// [rtl/usb_cap_pkg.sv]
package usb_cap_pkg;
    typedef logic [7:0] addr_t;
    typedef logic [31:0] word_t;
    typedef enum logic [1:0] {
        bus_idle,
        bus_answer
    } bus_state_e;
endpackage

// [rtl/usb_port_if.sv]
`timescale 1ns/10ps
interface usb_port_if #(parameter int N = 15);
    logic [N-1:0] power_wr;
    logic [N-1:0] power_val;
    logic [N-1:0] power_on;
    logic switch_present;
    modport ctrl (input power_wr, input power_val, input switch_present, output power_on);
    modport user (output power_wr, output power_val, output switch_present, input power_on);
endinterface

// [rtl/usb_port_power.sv]
`timescale 1ns/10ps
module usb_port_power #(
    parameter int N = 2
) (
    input wire logic clk_sys,
    input wire logic reset,
    usb_port_if.ctrl pif
);
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_port
            logic power_r;
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    power_r <= 1'b0;
                end else if (!pif.switch_present) begin
                    power_r <= 1'b1; // RQ2
                end else if (pif.power_wr[g]) begin
                    power_r <= pif.power_val[g]; // RQ2
                end
            end
            assign pif.power_on[g] = power_r;
        end
    endgenerate
endmodule // usb_port_power

// [bench/usb_cap_properties.sv]
`timescale 1ns/10ps
module usb_cap_properties import usb_cap_pkg::*; #(
    parameter int PORT_COUNT = 2,
    parameter bit POWER_SWITCH = 1'b1
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire usb_cap_pkg::addr_t avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire usb_cap_pkg::word_t avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire usb_cap_pkg::word_t avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [14:0] port_power
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_rd(a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence
    sequence s_wr;
        avs_write && !avs_waitrequest;
    endsequence
    a_read_answer: assert property (avs_read && avs_waitrequest |-> ##[1:4] !avs_waitrequest) else $error("no ack");
    a_switch_bit: assert property (s_rd(8'h04) |-> avs_readdata[4] == POWER_SWITCH) else $error("switch bit");
    a_port_count: assert property (s_rd(8'h04) |-> avs_readdata[3:0] == 4'(PORT_COUNT)) else $error("count");
    a_count_nonzero: assert property (s_rd(8'h04) |-> avs_readdata[3:0] != 4'h0) else $error("zero count");
    a_struct_upper: assert property (s_rd(8'h04) |-> avs_readdata[31:5] == 27'h0) else $error("upper bits");
    a_cap_word: assert property (s_rd(8'h08) |-> avs_readdata == 32'h0) else $error("cap word");
    a_power_range: assert property ((port_power >> PORT_COUNT) == 15'h0) else $error("extra port");
    a_power_write: assert property (POWER_SWITCH && s_wr ##0 avs_address == 8'h40 |=> port_power[0] == $past(avs_writedata[12])) else $error("power");
    a_ro_ignored: assert property (s_wr ##0 avs_address < 8'h40 |-> $stable(port_power)) else $error("ro write");
endmodule // usb_cap_properties

// [bench/usb_host_capability_params_tb.sv]
`timescale 1ns/10ps
module usb_host_capability_params_tb;
    import usb_cap_pkg::*;
    logic clk_sys, reset, avs_read, avs_write;
    addr_t avs_address;
    word_t avs_writedata, avs_readdata, q;
    word_t avs_readdata2, q2;
    logic avs_waitrequest;
    logic avs_waitrequest2;
    logic [14:0] port_power;
    logic [14:0] port_power2;
    int fails = 0;
    int checks_done = 0;
    usb_host_capability_params #(.PORT_COUNT(2), .POWER_SWITCH(1'b1)) i_dut (.clk_sys(clk_sys), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_power(port_power));
    // second instance without power switches, sharing the bus inputs
    usb_host_capability_params #(.PORT_COUNT(3), .POWER_SWITCH(1'b0)) i_dut_nsw (.clk_sys(clk_sys), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata2), .avs_waitrequest(avs_waitrequest2),
        .port_power(port_power2));
    initial begin
        clk_sys = 0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic final_report;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input word_t s, input word_t e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("FAIL %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic wr, input addr_t a, input word_t d, output word_t r);
        int n;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        r = avs_readdata;
        q2 = avs_readdata2;
        avs_write <= 0;
        avs_read <= 0;
        if (n == 20) begin
            fails++;
            final_report();
        end
        @(posedge clk_sys);
    endtask
    task automatic t_struct;
        bus(0, 8'h04, 0, q);
        chk(q[4], 1);
        chk(q[3:0], 2);
        chk(q[3:0] != 0, 1);
        chk(q, 32'h12);
        chk(q2, 32'h03);
        $display("struct done");
    endtask
    task automatic t_readonly;
        bus(0, 8'h08, 0, q);
        chk(q, 0);
        bus(1, 8'h08, 32'hffff_ffff, q);
        bus(1, 8'h04, 32'hffff_ffff, q);
        bus(0, 8'h08, 0, q);
        chk(q, 0);
        bus(0, 8'h04, 0, q);
        chk(q, 32'h12);
        $display("readonly done");
    endtask
    task automatic t_ports;
        bus(1, 8'h40, 32'h1000, q);
        chk(port_power, 1);
        bus(1, 8'h44, 32'h1000, q);
        bus(1, 8'h48, 32'h1000, q);
        chk(port_power, 3);
        bus(0, 8'h48, 0, q);
        chk(q, 0);
        bus(1, 8'h40, 0, q);
        chk(port_power, 2);
        chk(port_power2, 15'h0007);
        bus(0, 8'h40, 0, q);
        chk(q2, 32'h1000);
        $display("ports done");
    endtask
    initial begin
        reset = 1;
        avs_read = 0;
        avs_write = 0;
        avs_address = 0;
        avs_writedata = 0;
        repeat (12) @(posedge clk_sys);
        reset <= 0;
        @(posedge clk_sys);
        t_struct();
        t_readonly();
        t_ports();
        final_report();
    end
endmodule // usb_host_capability_params_tb
bind usb_host_capability_params usb_cap_properties #(.PORT_COUNT(PORT_COUNT), .POWER_SWITCH(POWER_SWITCH)) i_props (.*);
